// ### hw/sol_pkg.sv
// Constants shared by the strap option latch
package sol_pkg;

  // ----------------------------------------------------------------
  // Strap vector layout
  // ----------------------------------------------------------------
  localparam int STRAP_W      = 11;
  localparam int DUAL_W       = 10;
  localparam int DUAL_BASE    = 1;
  localparam int BIT_XOVR     = 0;
  localparam int BIT_FLOW     = 1;
  localparam int BIT_BP       = 2;
  localparam int BIT_COL      = 3;
  localparam int BIT_BOFF     = 4;
  localparam int BIT_FRAME    = 5;
  localparam int BIT_P4DUP    = 6;
  localparam int BIT_P4FLOW   = 7;
  localparam int BIT_M5FLOW   = 8;
  localparam int BIT_M5DUP    = 9;
  localparam int BIT_M5SPD    = 10;
  localparam int BIT_CAPTURED = 15;
  localparam int BIT_OVR_EN   = 0;

  localparam logic [STRAP_W-1:0] STRAP_DEFAULT = 11'h000;

  // ----------------------------------------------------------------
  // Frame length limits in bytes
  // ----------------------------------------------------------------
  localparam int LEN_W = 11;
  localparam logic [LEN_W-1:0] LEN_TAGGED   = 11'h05F2;
  localparam logic [LEN_W-1:0] LEN_UNTAGGED = 11'h05EE;
  localparam logic [LEN_W-1:0] LEN_LARGE    = 11'h0600;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_STRAP_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_OVR_CTRL     = 8'h04;
  localparam logic [ADDR_W-1:0] REG_OVR_VALUE    = 8'h08;
  localparam logic [ADDR_W-1:0] REG_EFFECTIVE    = 8'h0C;
  localparam logic [DATA_W-1:0] DATA_ZERO        = 32'h0000_0000;

  typedef enum logic [1:0] {
    SOL_HOLD,
    SOL_RUN
  } sol_state_e;

endpackage : sol_pkg

// ### hw/sol_pin_sync.sv
// Two-stage synchroniser for the strap pin levels
`timescale 1ns/10ps
module sol_pin_sync
  import sol_pkg::*;
(
  // Clock
  input  wire logic               clk_sys,
  input  wire logic               clkEn,
  // Pins
  input  wire logic [STRAP_W-1:0] pinAsync,
  output logic      [STRAP_W-1:0] pinSync
);

  logic [STRAP_W-1:0] stage1_ff;
  logic [STRAP_W-1:0] stage2_ff;

  // No reset: the chain must keep sampling while reset is held
  always_ff @(posedge clk_sys) begin
    if (clkEn) begin
      stage1_ff <= pinAsync;
      stage2_ff <= stage1_ff;
    end
  end

  assign pinSync = stage2_ff;

endmodule : sol_pin_sync

// ### hw/sol_strap_option_latch.sv
// Strap option latch: samples strap pins at reset release into config
`timescale 1ns/10ps
// ------------------------------------------------------------------
// ------------------------------------------------------------------
module sol_strap_option_latch
  import sol_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              clkEn,
  // Strap pins
  input  wire logic              crossoverDisableStrapIn,
  input  wire logic [DUAL_W-1:0] dualPinIn,
  output logic      [DUAL_W-1:0] dualPinOut,
  output logic      [DUAL_W-1:0] dualPinOe,
  output logic                   pinPulldownEn,
  // Core data for the pins in normal use
  input  wire logic [DUAL_W-1:0] coreDataOut,
  // Register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdData,
  // Configuration
  output logic                   crossoverDisable,
  output logic                   flowControlEn,
  output logic                   backPressureEn,
  output logic                   keepCollisionPkts,
  output logic                   aggressiveBackoffEn,
  output logic      [LEN_W-1:0]  maxTaggedLen,
  output logic      [LEN_W-1:0]  maxUntaggedLen,
  output logic                   port4ForceFullDuplex,
  output logic                   port4ForceFlowCtrl,
  output logic                   mac5FlowControlEn,
  output logic                   mac5HalfDuplex,
  output logic                   mac5Speed10
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [STRAP_W-1:0] strapSync;
  logic [STRAP_W-1:0] strapLatched_ff;
  logic [STRAP_W-1:0] ovrValue_ff;
  logic [STRAP_W-1:0] effRaw;
  logic               ovrEn_ff;
  logic               captured_ff;
  sol_state_e         state_ff;

  sol_pin_sync sol_pin_sync_inst (
    .clk_sys  (clk_sys),
    .clkEn    (clkEn),
    .pinAsync ({dualPinIn, crossoverDisableStrapIn}),
    .pinSync  (strapSync)
  );

  // ----------------------------------------------------------------
  // Capture sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (clkEn) begin
      if (reset) begin
        state_ff <= SOL_HOLD;
      end else begin
        state_ff <= SOL_RUN;
      end
    end
  end

  // Latch at the first edge after release, then hold
  always_ff @(posedge clk_sys) begin
    if (clkEn) begin
      if (reset) begin
        strapLatched_ff <= STRAP_DEFAULT;
        captured_ff     <= 1'b0;
      end else begin
        case (state_ff)
          SOL_HOLD: begin
            strapLatched_ff <= strapSync;
            captured_ff     <= 1'b1;
          end
          SOL_RUN: begin
            strapLatched_ff <= strapLatched_ff;
            captured_ff     <= captured_ff;
          end
          default: begin
            strapLatched_ff <= strapLatched_ff;
            captured_ff     <= captured_ff;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Dual-use pin drive
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < DUAL_W; gi++) begin : gPin
      always_ff @(posedge clk_sys) begin
        if (clkEn) begin
          if (reset) begin
            dualPinOe[gi]  <= 1'b0;
            dualPinOut[gi] <= 1'b0;
          end else if (state_ff == SOL_HOLD) begin
            // Drive from the same edge that latches the strap level
            dualPinOe[gi]  <= 1'b1;
            dualPinOut[gi] <= coreDataOut[gi];
          end else begin
            dualPinOe[gi]  <= dualPinOe[gi];
            dualPinOut[gi] <= coreDataOut[gi];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (clkEn) begin
      if (reset) begin
        pinPulldownEn <= 1'b1;
      end else if (state_ff == SOL_HOLD) begin
        pinPulldownEn <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (clkEn) begin
      if (reset) begin
        ovrEn_ff    <= 1'b0;
        ovrValue_ff <= STRAP_DEFAULT;
      end else if (regWr) begin
        if (regAddr == REG_OVR_CTRL) begin
          ovrEn_ff <= regWrData[BIT_OVR_EN];
        end
        if (regAddr == REG_OVR_VALUE) begin
          ovrValue_ff <= regWrData[STRAP_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clkEn) begin
      if (reset || !regRd) begin
        regRdData <= DATA_ZERO;
      end else begin
        case (regAddr)
          REG_STRAP_STATUS: begin
            regRdData <= DATA_ZERO;
            regRdData[STRAP_W-1:0]  <= strapLatched_ff;
            regRdData[BIT_CAPTURED] <= captured_ff;
          end
          REG_OVR_CTRL: begin
            regRdData <= DATA_ZERO;
            regRdData[BIT_OVR_EN] <= ovrEn_ff;
          end
          REG_OVR_VALUE: begin
            regRdData <= DATA_ZERO;
            regRdData[STRAP_W-1:0] <= ovrValue_ff;
          end
          REG_EFFECTIVE: begin
            regRdData <= DATA_ZERO;
            regRdData[STRAP_W-1:0] <= effRaw;
          end
          default: begin
            regRdData <= DATA_ZERO;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  // Managing agent overrides, otherwise straps over defaults
  assign effRaw = ovrEn_ff ? ovrValue_ff : strapLatched_ff;

  always_ff @(posedge clk_sys) begin
    if (clkEn) begin
      if (reset) begin
        crossoverDisable     <= 1'b0;
        flowControlEn        <= 1'b1;
        backPressureEn       <= 1'b0;
        keepCollisionPkts    <= 1'b0;
        aggressiveBackoffEn  <= 1'b0;
        maxTaggedLen         <= LEN_TAGGED;
        maxUntaggedLen       <= LEN_UNTAGGED;
        port4ForceFullDuplex <= 1'b0;
        port4ForceFlowCtrl   <= 1'b0;
        mac5FlowControlEn    <= 1'b0;
        mac5HalfDuplex       <= 1'b0;
        mac5Speed10          <= 1'b0;
      end else begin
        crossoverDisable     <= effRaw[BIT_XOVR];
        flowControlEn        <= ~effRaw[BIT_FLOW];
        backPressureEn       <= effRaw[BIT_BP];
        keepCollisionPkts    <= effRaw[BIT_COL];
        aggressiveBackoffEn  <= effRaw[BIT_BOFF];
        maxTaggedLen   <= effRaw[BIT_FRAME] ? LEN_LARGE : LEN_TAGGED;
        maxUntaggedLen <= effRaw[BIT_FRAME] ? LEN_LARGE : LEN_UNTAGGED;
        port4ForceFullDuplex <= effRaw[BIT_P4DUP];
        port4ForceFlowCtrl   <= effRaw[BIT_P4FLOW];
        mac5FlowControlEn    <= effRaw[BIT_M5FLOW];
        mac5HalfDuplex       <= effRaw[BIT_M5DUP];
        mac5Speed10          <= effRaw[BIT_M5SPD];
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_DEFAULT_IN_RESET: assert property (
    @(posedge clk_sys) (reset && clkEn) |=>
      (!crossoverDisable && flowControlEn && !mac5Speed10 && maxTaggedLen == LEN_TAGGED))
    else $error("Config not at defaults during reset");

  AST_INPUT_IN_RESET: assert property (
    @(posedge clk_sys) (reset && clkEn) |=> (dualPinOe == '0 && pinPulldownEn))
    else $error("Dual-use pin driven during reset");

  AST_OUTPUT_AFTER_RESET: assert property (
    @(posedge clk_sys)
      ((reset && clkEn) ##1 (!reset && clkEn)) |=>
        (dualPinOe == '1 && !pinPulldownEn && captured_ff))
    else $error("Dual-use pin not an output after reset release");

  AST_STRAP_DEFAULTS: assert property (
    @(posedge clk_sys) disable iff (reset)
      (captured_ff && !ovrEn_ff && clkEn) |=>
        (backPressureEn == $past(strapLatched_ff[BIT_BP])
         && keepCollisionPkts == $past(strapLatched_ff[BIT_COL])
         && aggressiveBackoffEn == $past(strapLatched_ff[BIT_BOFF])))
    else $error("Straps not applied without override");

  AST_CROSSOVER: assert property (
    @(posedge clk_sys) disable iff (reset)
      (clkEn ##1 clkEn) |-> (crossoverDisable == $past(effRaw[BIT_XOVR])))
    else $error("Crossover disable mismatch");

  AST_FLOW_POLARITY: assert property (
    @(posedge clk_sys) disable iff (reset)
      (clkEn && captured_ff) |=> (flowControlEn != $past(effRaw[BIT_FLOW])))
    else $error("Flow control polarity wrong");

  AST_FRAME_SIZE: assert property (
    @(posedge clk_sys) disable iff (reset)
      (clkEn && effRaw[BIT_FRAME]) |=> (maxTaggedLen == LEN_LARGE && maxUntaggedLen == LEN_LARGE))
    else $error("Large frame limit not applied");

  AST_PORT4: assert property (
    @(posedge clk_sys) disable iff (reset)
      clkEn |=> (port4ForceFullDuplex == $past(effRaw[BIT_P4DUP])
                 && port4ForceFlowCtrl == $past(effRaw[BIT_P4FLOW])))
    else $error("Port 4 forced settings mismatch");

  AST_MAC5: assert property (
    @(posedge clk_sys) disable iff (reset)
      clkEn |=> (mac5HalfDuplex == $past(effRaw[BIT_M5DUP])
                 && mac5Speed10 == $past(effRaw[BIT_M5SPD])
                 && mac5FlowControlEn == $past(effRaw[BIT_M5FLOW])))
    else $error("MAC 5 settings mismatch");

  AST_HOLD_LATCH: assert property (
    @(posedge clk_sys) disable iff (reset)
      captured_ff |=> $stable(strapLatched_ff))
    else $error("Latched straps changed after capture");

  COV_CAPTURE: cover property (
    @(posedge clk_sys) reset ##1 (!reset && clkEn) ##1 captured_ff);

  COV_OVERRIDE: cover property (
    @(posedge clk_sys) disable iff (reset)
      (regWr && regAddr == REG_OVR_CTRL && regWrData[BIT_OVR_EN]) ##1 ovrEn_ff);

  COV_LARGE_FRAME: cover property (
    @(posedge clk_sys) disable iff (reset) maxTaggedLen == LEN_LARGE);

  COV_READ_STATUS: cover property (
    @(posedge clk_sys) disable iff (reset)
      (regRd && regAddr == REG_STRAP_STATUS) ##1 regRdData[BIT_CAPTURED]);

endmodule : sol_strap_option_latch

// ### tb/sol_strap_board.sv
// Board resistors on the strap pins, the far side of the latch
`timescale 1ns/10ps
module sol_strap_board
  import sol_pkg::*;
(
  // Resistor fitting, 1 = pull-up, 0 = pull-down
  input  wire logic [STRAP_W-1:0] strapPullUp,
  // Device side of the dual-use pins
  input  wire logic [DUAL_W-1:0]  dualPinOut,
  input  wire logic [DUAL_W-1:0]  dualPinOe,
  // Resolved pin levels
  output logic                    crossoverPin,
  output logic      [DUAL_W-1:0]  dualPinLevel
);
  // ----------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------
  // Released pin falls to its resistor, never to the last driven value
  always_comb begin
    crossoverPin = strapPullUp[BIT_XOVR];
    for (int i = 0; i < DUAL_W; i++) begin
      dualPinLevel[i] = dualPinOe[i] ? dualPinOut[i] : strapPullUp[DUAL_BASE+i];
    end
  end
endmodule : sol_strap_board

// ### tb/sol_strap_option_latch_bench.sv
// Self-checking bench for the strap option latch
`timescale 1ns/10ps
module sol_strap_option_latch_bench
  import sol_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic               clk_sys = 1'b0;
  logic               reset   = 1'b1;
  logic               clkEn   = 1'b1;
  logic [STRAP_W-1:0] strapSet = 11'h000;
  logic               crossoverPin;
  logic [DUAL_W-1:0]  dualPinLevel, dualPinOut, dualPinOe, coreDataOut = 10'h000;
  logic               pinPulldownEn;
  logic [ADDR_W-1:0]  regAddr = 8'h00;
  logic [DATA_W-1:0]  regWrData = 32'h0000_0000, regRdData, rdVal;
  logic               regWr = 1'b0, regRd = 1'b0;
  logic               crossoverDisable, flowControlEn, backPressureEn, keepCollisionPkts;
  logic               aggressiveBackoffEn, port4ForceFullDuplex, port4ForceFlowCtrl;
  logic               mac5FlowControlEn, mac5HalfDuplex, mac5Speed10;
  logic [LEN_W-1:0]   maxTaggedLen, maxUntaggedLen;
  logic [31:0]        cfgSeen;
  int                 badCount = 0, checksDone = 0;

  always #5 clk_sys = ~clk_sys;

  assign cfgSeen = {maxTaggedLen, maxUntaggedLen, mac5Speed10, mac5HalfDuplex,
                    mac5FlowControlEn, port4ForceFlowCtrl, port4ForceFullDuplex,
                    aggressiveBackoffEn, keepCollisionPkts, backPressureEn,
                    flowControlEn, crossoverDisable};

  sol_strap_board sol_strap_board_inst (
    .strapPullUp (strapSet), .dualPinOut (dualPinOut), .dualPinOe (dualPinOe),
    .crossoverPin (crossoverPin), .dualPinLevel (dualPinLevel));

  sol_strap_option_latch sol_strap_option_latch_inst (
    .clk_sys (clk_sys), .reset (reset), .clkEn (clkEn),
    .crossoverDisableStrapIn (crossoverPin), .dualPinIn (dualPinLevel),
    .dualPinOut (dualPinOut), .dualPinOe (dualPinOe), .pinPulldownEn (pinPulldownEn),
    .coreDataOut (coreDataOut), .regAddr (regAddr), .regWrData (regWrData),
    .regWr (regWr), .regRd (regRd), .regRdData (regRdData),
    .crossoverDisable (crossoverDisable), .flowControlEn (flowControlEn),
    .backPressureEn (backPressureEn), .keepCollisionPkts (keepCollisionPkts),
    .aggressiveBackoffEn (aggressiveBackoffEn), .maxTaggedLen (maxTaggedLen),
    .maxUntaggedLen (maxUntaggedLen), .port4ForceFullDuplex (port4ForceFullDuplex),
    .port4ForceFlowCtrl (port4ForceFlowCtrl), .mac5FlowControlEn (mac5FlowControlEn),
    .mac5HalfDuplex (mac5HalfDuplex), .mac5Speed10 (mac5Speed10));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Expected outputs in the bit order of cfgSeen
  function automatic logic [31:0] expCfg(input logic [STRAP_W-1:0] s);
    expCfg = {s[5] ? 11'h0600 : 11'h05F2, s[5] ? 11'h0600 : 11'h05EE,
              s[10:6], s[4:2], ~s[1], s[0]};
  endfunction : expCfg

  task automatic checkVal(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : checkVal

  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrapUp

  task automatic regWrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1; regAddr <= a; regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : regWrite

  task automatic regRead(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    regRd <= 1'b1; regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask : regRead

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset with given resistors, check reset state, capture and decode
  task automatic captureCheck(input logic [STRAP_W-1:0] s);
    @(posedge clk_sys);
    strapSet <= s; reset <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 checkVal("oe in reset", 32'(dualPinOe), 32'h0000_0000);
    checkVal("out in reset", 32'(dualPinOut), 32'h0000_0000);
    checkVal("pulldown in reset", 32'(pinPulldownEn), 32'h0000_0001);
    checkVal("cfg in reset", cfgSeen, expCfg(11'h000));
    reset <= 1'b0;
    @(posedge clk_sys);
    #1 checkVal("oe after capture", 32'(dualPinOe), 32'h0000_03FF);
    checkVal("pulldown after capture", 32'(pinPulldownEn), 32'h0000_0000);
    checkVal("cfg at capture edge", cfgSeen, expCfg(11'h000));
    @(posedge clk_sys);
    #1 checkVal("cfg decoded", cfgSeen, expCfg(s));
    regRead(REG_STRAP_STATUS, rdVal);
    checkVal("status", rdVal, 32'h0000_8000 | 32'(s));
  endtask : captureCheck

  // Every strap alone, none and all
  task automatic scenSweep();
    captureCheck(11'h000);
    for (int i = 0; i < STRAP_W; i++) begin
      captureCheck(11'h001 << i);
    end
    captureCheck(11'h7FF);
  endtask : scenSweep

  // Straps flip while pins drive: config holds, pins carry core data
  task automatic scenHold();
    captureCheck(11'h555);
    @(posedge clk_sys);
    strapSet <= 11'h2AA; coreDataOut <= 10'h2C9;
    repeat (2) @(posedge clk_sys);
    #1 checkVal("pin data", 32'(dualPinLevel), 32'h0000_02C9);
    checkVal("cfg held", cfgSeen, expCfg(11'h555));
    @(posedge clk_sys);
    coreDataOut <= 10'h136;
    #1 checkVal("pin data lag", 32'(dualPinOut), 32'h0000_02C9);
    @(posedge clk_sys);
    #1 checkVal("pin data new", 32'(dualPinOut), 32'h0000_0136);
  endtask : scenHold

  // Managing agent override, read-only and unmapped places
  task automatic scenRegisters();
    captureCheck(11'h000);
    regWrite(REG_OVR_VALUE, 32'hFFFF_FFFF);
    regWrite(REG_OVR_CTRL, 32'h0000_0001);
    repeat (2) @(posedge clk_sys);
    #1 checkVal("cfg override", cfgSeen, expCfg(11'h7FF));
    regRead(REG_OVR_VALUE, rdVal);
    checkVal("override value", rdVal, 32'h0000_07FF);
    regRead(REG_OVR_CTRL, rdVal);
    checkVal("override ctrl", rdVal, 32'h0000_0001);
    regRead(REG_EFFECTIVE, rdVal);
    checkVal("effective", rdVal, 32'h0000_07FF);
    @(posedge clk_sys);
    #1 checkVal("read data one cycle", regRdData, 32'h0000_0000);
    regWrite(REG_STRAP_STATUS, 32'h0000_FFFF);
    regRead(REG_STRAP_STATUS, rdVal);
    checkVal("status read only", rdVal, 32'h0000_8000);
    regRead(8'h10, rdVal);
    checkVal("unmapped", rdVal, 32'h0000_0000);
    regWrite(REG_OVR_CTRL, 32'h0000_0000);
    repeat (2) @(posedge clk_sys);
    #1 checkVal("cfg straps again", cfgSeen, expCfg(11'h000));
  endtask : scenRegisters

  // Clock enable low: writes refused, configuration frozen
  task automatic scenFreeze();
    captureCheck(11'h000);
    @(posedge clk_sys);
    clkEn <= 1'b0;
    regWrite(REG_OVR_VALUE, 32'h0000_07FF);
    regWrite(REG_OVR_CTRL, 32'h0000_0001);
    repeat (2) @(posedge clk_sys);
    #1 checkVal("cfg frozen", cfgSeen, expCfg(11'h000));
    clkEn <= 1'b1;
    regRead(REG_OVR_CTRL, rdVal);
    checkVal("ctrl after freeze", rdVal, 32'h0000_0000);
    regRead(REG_OVR_VALUE, rdVal);
    checkVal("value after freeze", rdVal, 32'h0000_0000);
  endtask : scenFreeze

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys);
    // Reset stays high into the first capture so the sync chain fills
    scenSweep();
    scenHold();
    scenRegisters();
    scenFreeze();
    wrapUp();
  end

  initial begin
    repeat (32'h0000_4E20) @(posedge clk_sys);
    badCount++;
    wrapUp();
  end
endmodule : sol_strap_option_latch_bench
